// file: shared/tbr_regs.svh
/*
  Constants of the tag read command: codes, record layout,
  key selector fields and result codes.
  Assumes inclusion by the design files that need it.
*/
`ifndef TBR_REGS_SVH
`define TBR_REGS_SVH

// command codes
`define TBR_CMD_NOP 8'h00
`define TBR_CMD_READ_BLOCK 8'h02

// parameter record byte offsets
`define TBR_PAR_BLOCK 4'h0
`define TBR_PAR_COUNT 4'h1
`define TBR_PAR_OFFSET 4'h2
`define TBR_PAR_KEYSEL 4'h3
`define TBR_PAR_KEY 4'h4
`define TBR_PAR_BYTES 10
`define TBR_KEY_BYTES 6

// key selector fields
`define TBR_SEL_KEYB_BIT 7
`define TBR_SEL_INLINE_BIT 6
`define TBR_SEL_IDX_W 6
`define TBR_KEY_MAX 6'h27

// tag block size in bytes
`define TBR_BLK_BYTES 16

// result codes
`define TBR_RES_NONE 8'h00
`define TBR_RES_AUTH_FAIL 8'h01
`define TBR_RES_READ_FAIL 8'h02
`define TBR_RES_BAD_PARAM 8'h03
`define TBR_RES_UNKNOWN 8'h04

`endif

// file: shared/tbr_pkg.sv
/*
  Types of the multi-block tag read command block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tbr_pkg;

    // command sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_PARSE,
        ST_LOADKEY,
        ST_AUTH,
        ST_AUTH_WAIT,
        ST_READ,
        ST_READ_WAIT,
        ST_COMMIT,
        ST_NEXT,
        ST_FINISH
    } tbr_state_e;

endpackage

// file: design/tbr_byte_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; ready and valid come from flip-flops.
*/
module tbr_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // drain side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] memQ [DEPTH];
    logic [AW-1:0] wrPtrQ;
    logic [AW-1:0] rdPtrQ;
    logic [CW-1:0] countQ;
    logic [CW-1:0] countD;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = memQ[rdPtrQ];

    // occupancy after this cycle's push and pop
    always_comb begin
        countD = countQ;
        if (push && !pop) begin
            countD = countQ + 1'b1;
        end else if (pop && !push) begin
            countD = countQ - 1'b1;
        end
    end

    // storage, no reset needed for data
    always_ff @(posedge clk) begin
        if (push) begin
            memQ[wrPtrQ] <= inData;
        end
    end

    // pointers and registered flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            countQ <= '0;
            inReady <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (push) wrPtrQ <= nextPtr(wrPtrQ);
            if (pop) rdPtrQ <= nextPtr(rdPtrQ);
            countQ <= countD;
            inReady <= (countD != CW'(DEPTH));
            outValid <= (countD != '0);
        end
    end
endmodule

// file: design/tbr_key_store.sv
/*
  Stored authentication keys, one write port, registered read.
  Assumes the host loads keys before issuing commands.
*/
module tbr_key_store #(
    parameter int NKEYS = 40,
    parameter int KEYW = 48,
    parameter int IW = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // load port
    input wire logic wrEn,
    input wire logic [IW-1:0] wrIdx,
    input wire logic [KEYW-1:0] wrData,
    // lookup port, one cycle latency
    input wire logic [IW-1:0] rdIdx,
    output logic [KEYW-1:0] rdData
);
    logic [KEYW-1:0] memQ [NKEYS];

    // out-of-range indices are dropped on write
    always_ff @(posedge clk) begin
        if (wrEn && (int'(wrIdx) < NKEYS)) begin
            memQ[wrIdx] <= wrData;
        end
    end

    // out-of-range lookup reads as zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= '0;
        end else if (int'(rdIdx) < NKEYS) begin
            rdData <= memQ[rdIdx];
        end else begin
            rdData <= '0;
        end
    end
endmodule

// file: design/tbr_read_cmd.sv
/*
  Multi-block tag read command: takes the command code and the
  parameter record from the host, authenticates each tag sector,
  reads blocks through a byte FIFO, stages each block and copies it
  into the data buffer, then posts a result code.
  Assumes tag engine and host run on clk, and that the engine
  reports block done only after its last byte was accepted.
*/
// Notes on behaviour
// - command code 0x02 starts the multi-block tag read
// - record: block, count, offset, key selector, then six key bytes
// - low six selector bits index stored keys 0 to 39
// - selector bit 7 picks key B, else key A
// - selector bit 6 takes the key inline from the record
// - inline key is least significant byte first
// - authenticate the first block's sector before any read
// - failed authentication posts its error and ends the command
// - read first block, then following blocks while count exceeds one
// - a block in a new sector is authenticated with the same key
// - on success bytes land contiguously from offset, result no error
// - a block read failure posts an error result
// - busy output held low while parsing and executing
// - result updated at the end of every command
`include "tbr_regs.svh"
module tbr_read_cmd
    import tbr_pkg::*;
#(
    parameter int BUF_LEN = 256,
    parameter int BUF_AW = 8,
    parameter int SECTOR_BLOCKS = 4,
    parameter int FIFO_DEPTH = 4,
    parameter int NKEYS = 40
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // host command, parameter record and key loading
    input wire logic cmdWrEn,
    input wire logic [7:0] cmdWrData,
    input wire logic paramWrEn,
    input wire logic [3:0] paramWrAddr,
    input wire logic [7:0] paramWrData,
    input wire logic keyWrEn,
    input wire logic [5:0] keyWrIdx,
    input wire logic [47:0] keyWrData,
    // host status
    output logic moduleBusyLow,
    output logic [7:0] resultCode,
    output logic resultStrobe,
    // tag engine requests
    output logic tagCmdValid,
    output logic tagCmdAuth,
    output logic tagCmdKeyB,
    output logic [7:0] tagCmdBlock,
    output logic [47:0] tagCmdKey,
    input wire logic tagCmdReady,
    input wire logic tagDoneValid,
    input wire logic tagDoneOk,
    // tag read data stream
    input wire logic tagByteValid,
    input wire logic [7:0] tagByte,
    output logic tagByteReady,
    // data buffer write port
    output logic bufWrEn,
    output logic [BUF_AW-1:0] bufWrAddr,
    output logic [7:0] bufWrData
);
    localparam int SW = (SECTOR_BLOCKS > 1) ? $clog2(SECTOR_BLOCKS) : 0;

    tbr_state_e stateQ;
    logic [7:0] cmdQ;
    logic [7:0] paramQ [`TBR_PAR_BYTES];
    logic [7:0] blkQ;
    logic [7:0] remainQ;
    logic [7:0] errQ;
    logic [47:0] keyQ;
    logic keyBQ;
    logic [7:0] stageQ [`TBR_BLK_BYTES];
    logic [4:0] stageCntQ;
    logic doneSeenQ;
    logic doneOkQ;
    logic [3:0] commitIdxQ;
    logic [BUF_AW-1:0] wrPtrQ;
    logic [47:0] keyRdData;
    logic fifoOutValid;
    logic [7:0] fifoOutData;
    logic fifoOutReady;
    logic [7:0] keySel;
    logic handshake;

    // end of the requested buffer range, one past the last byte
    function automatic logic [12:0] rangeEnd(input logic [7:0] offs,
                                             input logic [7:0] cnt);
        return {5'h00, offs} + {1'b0, cnt, 4'h0};
    endfunction

    // tag sector that holds a block
    function automatic logic [7:0] sectorOf(input logic [7:0] blk);
        return blk >> SW;
    endfunction

    assign keySel = paramQ[`TBR_PAR_KEYSEL];
    assign handshake = tagCmdValid && tagCmdReady;
    // drain only while a block is being collected
    assign fifoOutReady = (stateQ == ST_READ_WAIT);

    // stored keys, looked up by the selector's low bits
    tbr_key_store #(
        .NKEYS(NKEYS),
        .KEYW(48),
        .IW(`TBR_SEL_IDX_W)
    ) keyStore (
        .clk(clk),
        .reset_n(reset_n),
        .wrEn(keyWrEn),
        .wrIdx(keyWrIdx),
        .wrData(keyWrData),
        .rdIdx(keySel[`TBR_SEL_IDX_W-1:0]),
        .rdData(keyRdData)
    );

    // tag bytes pass a small FIFO; a full FIFO stalls the tag engine
    tbr_byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) byteFifo (
        .clk(clk),
        .reset_n(reset_n),
        .inValid(tagByteValid),
        .inData(tagByte),
        .inReady(tagByteReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData),
        .outReady(fifoOutReady)
    );

    // parameter record, writable only while idle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `TBR_PAR_BYTES; i++) begin
                paramQ[i] <= 8'h00;
            end
        end else if (stateQ == ST_IDLE && paramWrEn &&
                     int'(paramWrAddr) < `TBR_PAR_BYTES) begin
            paramQ[paramWrAddr] <= paramWrData;
        end
    end

    // command sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stateQ <= ST_IDLE;
            cmdQ <= 8'h00;
            blkQ <= 8'h00;
            remainQ <= 8'h00;
            errQ <= `TBR_RES_NONE;
            keyQ <= 48'h0;
            keyBQ <= 1'b0;
        end else begin
            case (stateQ)
                ST_IDLE: begin
                    if (cmdWrEn) begin
                        cmdQ <= cmdWrData;
                        stateQ <= ST_PARSE;
                    end
                end
                ST_PARSE: begin
                    if (cmdQ == `TBR_CMD_READ_BLOCK) begin
                        // guard against a bad record rather than trust it
                        if (paramQ[`TBR_PAR_COUNT] == 8'h00 ||
                            rangeEnd(paramQ[`TBR_PAR_OFFSET],
                                     paramQ[`TBR_PAR_COUNT]) >
                            13'(BUF_LEN)) begin
                            errQ <= `TBR_RES_BAD_PARAM;
                            stateQ <= ST_FINISH;
                        end else begin
                            stateQ <= ST_LOADKEY;
                        end
                    end else if (cmdQ == `TBR_CMD_NOP) begin
                        errQ <= `TBR_RES_NONE;
                        stateQ <= ST_FINISH;
                    end else begin
                        errQ <= `TBR_RES_UNKNOWN;
                        stateQ <= ST_FINISH;
                    end
                end
                ST_LOADKEY: begin
                    keyBQ <= keySel[`TBR_SEL_KEYB_BIT];
                    blkQ <= paramQ[`TBR_PAR_BLOCK];
                    remainQ <= paramQ[`TBR_PAR_COUNT];
                    if (keySel[`TBR_SEL_INLINE_BIT]) begin
                        for (int i = 0; i < `TBR_KEY_BYTES; i++) begin
                            keyQ[8*i +: 8] <= paramQ[`TBR_PAR_KEY + i];
                        end
                        stateQ <= ST_AUTH;
                    end else if (keySel[`TBR_SEL_IDX_W-1:0] >
                                 `TBR_KEY_MAX) begin
                        errQ <= `TBR_RES_BAD_PARAM;
                        stateQ <= ST_FINISH;
                    end else begin
                        keyQ <= keyRdData;
                        stateQ <= ST_AUTH;
                    end
                end
                ST_AUTH: begin
                    if (handshake) stateQ <= ST_AUTH_WAIT;
                end
                ST_AUTH_WAIT: begin
                    if (tagDoneValid) begin
                        if (tagDoneOk) begin
                            stateQ <= ST_READ;
                        end else begin
                            errQ <= `TBR_RES_AUTH_FAIL;
                            stateQ <= ST_FINISH;
                        end
                    end
                end
                ST_READ: begin
                    if (handshake) stateQ <= ST_READ_WAIT;
                end
                ST_READ_WAIT: begin
                    // wait until the FIFO is drained so no byte is left
                    if (doneSeenQ && !fifoOutValid) begin
                        if (doneOkQ &&
                            stageCntQ == 5'(`TBR_BLK_BYTES)) begin
                            stateQ <= ST_COMMIT;
                        end else begin
                            errQ <= `TBR_RES_READ_FAIL;
                            stateQ <= ST_FINISH;
                        end
                    end
                end
                ST_COMMIT: begin
                    if (commitIdxQ == 4'(`TBR_BLK_BYTES - 1)) begin
                        stateQ <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    remainQ <= remainQ - 8'h01;
                    if (remainQ == 8'h01) begin
                        errQ <= `TBR_RES_NONE;
                        stateQ <= ST_FINISH;
                    end else begin
                        blkQ <= blkQ + 8'h01;
                        if (sectorOf(blkQ + 8'h01) != sectorOf(blkQ)) begin
                            stateQ <= ST_AUTH;
                        end else begin
                            stateQ <= ST_READ;
                        end
                    end
                end
                ST_FINISH: begin
                    stateQ <= ST_IDLE;
                end
                default: begin
                    stateQ <= ST_IDLE;
                end
            endcase
        end
    end

    // tag engine request, held until the engine accepts it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tagCmdValid <= 1'b0;
            tagCmdAuth <= 1'b0;
            tagCmdKeyB <= 1'b0;
            tagCmdBlock <= 8'h00;
            tagCmdKey <= 48'h0;
        end else if (handshake) begin
            tagCmdValid <= 1'b0;
        end else if (!tagCmdValid &&
                     (stateQ == ST_AUTH || stateQ == ST_READ)) begin
            tagCmdValid <= 1'b1;
            tagCmdAuth <= (stateQ == ST_AUTH);
            tagCmdKeyB <= keyBQ;
            tagCmdBlock <= blkQ;
            tagCmdKey <= keyQ;
        end
    end

    // staging of one block; bytes beyond a block are dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stageCntQ <= 5'h00;
            doneSeenQ <= 1'b0;
            doneOkQ <= 1'b0;
        end else if (stateQ == ST_READ) begin
            stageCntQ <= 5'h00;
            doneSeenQ <= 1'b0;
            doneOkQ <= 1'b0;
        end else if (stateQ == ST_READ_WAIT) begin
            if (fifoOutValid && stageCntQ < 5'(`TBR_BLK_BYTES)) begin
                stageCntQ <= stageCntQ + 5'h01;
            end
            if (tagDoneValid) begin
                doneSeenQ <= 1'b1;
                doneOkQ <= tagDoneOk;
            end
        end
    end

    // staging storage, data only
    always_ff @(posedge clk) begin
        if (stateQ == ST_READ_WAIT && fifoOutValid &&
            stageCntQ < 5'(`TBR_BLK_BYTES)) begin
            stageQ[stageCntQ[3:0]] <= fifoOutData;
        end
    end

    // copy a verified block into the buffer, a byte a cycle;
    // a failed block never reaches here, so the buffer keeps old data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bufWrEn <= 1'b0;
            bufWrAddr <= '0;
            bufWrData <= 8'h00;
            commitIdxQ <= 4'h0;
            wrPtrQ <= '0;
        end else if (stateQ == ST_LOADKEY) begin
            bufWrEn <= 1'b0;
            wrPtrQ <= BUF_AW'(paramQ[`TBR_PAR_OFFSET]);
        end else if (stateQ == ST_COMMIT) begin
            bufWrEn <= 1'b1;
            bufWrAddr <= wrPtrQ;
            bufWrData <= stageQ[commitIdxQ];
            wrPtrQ <= wrPtrQ + 1'b1;
            commitIdxQ <= commitIdxQ + 4'h1;
        end else begin
            bufWrEn <= 1'b0;
            commitIdxQ <= 4'h0;
        end
    end

    // busy line and result posting
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            moduleBusyLow <= 1'b1;
            resultCode <= `TBR_RES_NONE;
            resultStrobe <= 1'b0;
        end else begin
            resultStrobe <= 1'b0;
            if (stateQ == ST_IDLE && cmdWrEn) begin
                moduleBusyLow <= 1'b0;
            end else if (stateQ == ST_FINISH) begin
                moduleBusyLow <= 1'b1;
                resultCode <= errQ;
                resultStrobe <= 1'b1;
            end
        end
    end
endmodule

// file: tb/tbr_read_cmd_chk.sv
/*
  Concurrent checks on the ports of the tag block read command.
  Assumes it is bound into tbr_read_cmd; one clock, async low reset.
*/
module tbr_read_cmd_chk #(
    parameter int BUF_AW = 8,
    parameter int SECTOR_BLOCKS = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // host side
    input wire logic cmdWrEn,
    input wire logic [7:0] cmdWrData,
    input wire logic moduleBusyLow,
    input wire logic [7:0] resultCode,
    input wire logic resultStrobe,
    // tag and buffer side
    input wire logic tagCmdValid,
    input wire logic tagCmdAuth,
    input wire logic [7:0] tagCmdBlock,
    input wire logic tagCmdReady,
    input wire logic bufWrEn,
    input wire logic [BUF_AW-1:0] bufWrAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic authSeen_q;
    logic [7:0] authSec_q;
    logic idleTake;
    // busy is high only while the sequencer is idle
    assign idleTake = moduleBusyLow && cmdWrEn;
    // sector of the last accepted auth
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            authSeen_q <= 1'b0;
            authSec_q <= 8'h00;
        end else if (tagCmdValid && tagCmdReady && tagCmdAuth) begin
            authSeen_q <= 1'b1;
            authSec_q <= 8'(tagCmdBlock / SECTOR_BLOCKS);
        end else if (moduleBusyLow) begin
            authSeen_q <= 1'b0;
        end
    end
    busy_take_a:
    assert property (idleTake |=> !moduleBusyLow)
        else $error("busy not low after command");
    strobe_end_a:
    assert property (resultStrobe == $rose(moduleBusyLow))
        else $error("strobe and busy release apart");
    nop_done_a:
    assert property (idleTake && cmdWrData == 8'h00 |->
        ##3 resultStrobe && resultCode == 8'h00)
        else $error("no-action result wrong");
    unk_done_a:
    assert property (idleTake && cmdWrData != 8'h00 && cmdWrData != 8'h02
        |-> ##3 resultStrobe && resultCode == 8'h04)
        else $error("unknown command result wrong");
    result_hold_a:
    assert property (!resultStrobe |-> $stable(resultCode))
        else $error("result changed without strobe");
    req_hold_a:
    assert property (tagCmdValid && !tagCmdReady |=> tagCmdValid
        && $stable(tagCmdBlock) && $stable(tagCmdAuth))
        else $error("tag request dropped or changed");
    req_drop_a:
    assert property (tagCmdValid && tagCmdReady |=> !tagCmdValid)
        else $error("second request outstanding");
    read_auth_a:
    assert property (tagCmdValid && !tagCmdAuth |-> authSeen_q
        && 8'(tagCmdBlock / SECTOR_BLOCKS) == authSec_q)
        else $error("read of unauthenticated sector");
    buf_step_a:
    assert property (bufWrEn ##1 bufWrEn |->
        bufWrAddr == BUF_AW'($past(bufWrAddr) + 1'b1))
        else $error("buffer writes not contiguous");
    buf_busy_a:
    assert property (bufWrEn |-> !moduleBusyLow)
        else $error("buffer write while idle");
    cover property (resultStrobe && resultCode == 8'h01);
    cover property (resultStrobe && resultCode == 8'h02);
    cover property (tagCmdValid && tagCmdReady && !tagCmdAuth);
endmodule

bind tbr_read_cmd tbr_read_cmd_chk #(.BUF_AW(BUF_AW),
    .SECTOR_BLOCKS(SECTOR_BLOCKS)) tbr_read_cmd_chk_i (.clk, .reset_n,
    .cmdWrEn, .cmdWrData, .moduleBusyLow, .resultCode, .resultStrobe,
    .tagCmdValid, .tagCmdAuth, .tagCmdBlock, .tagCmdReady, .bufWrEn,
    .bufWrAddr);

// file: tb/tbr_tag_model.sv
/*
  Behavioural tag engine facing the block read command.
  Assumes requests held until ready; bench sets gap and fail
  blocks between commands.
*/
module tbr_tag_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // requests from the design
    input wire logic tagCmdValid,
    input wire logic tagCmdAuth,
    input wire logic tagCmdKeyB,
    input wire logic [7:0] tagCmdBlock,
    input wire logic [47:0] tagCmdKey,
    output logic tagCmdReady,
    output logic tagDoneValid,
    output logic tagDoneOk,
    // read data stream
    input wire logic tagByteReady,
    output logic tagByteValid,
    output logic [7:0] tagByte
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap = 0;
    int failAuth = -1;
    int failRead = -1;
    int nAuth = 0;
    int nRead = 0;
    logic lastKeyB;
    logic [47:0] lastKey;
    logic [7:0] blk;
    logic ok;
    // one request at a time, done after the last byte
    initial begin
        tagCmdReady = 1'b0;
        tagDoneValid = 1'b0;
        tagDoneOk = 1'b0;
        tagByteValid = 1'b0;
        tagByte = 8'h00;
        forever begin
            @(posedge clk);
            if (reset_n && tagCmdValid) begin
                repeat (gap) @(posedge clk);
                tagCmdReady <= 1'b1;
                @(posedge clk);
                tagCmdReady <= 1'b0;
                blk = tagCmdBlock;
                if (tagCmdAuth) begin
                    nAuth++;
                    lastKey = tagCmdKey;
                    lastKeyB = tagCmdKeyB;
                    ok = (int'(blk) != failAuth);
                end else begin
                    nRead++;
                    ok = (int'(blk) != failRead);
                    for (int i = 0; i < 16; i++) begin
                        repeat (gap) @(posedge clk);
                        tagByteValid <= 1'b1;
                        tagByte <= {blk[3:0], 4'(i)};
                        do @(posedge clk); while (tagByteReady !== 1'b1);
                        if (gap > 0 || i == 15) begin
                            tagByteValid <= 1'b0;
                            // no stale byte on a released bus
                            tagByte <= ~{blk[3:0], 4'(i)};
                        end
                    end
                end
                repeat (gap) @(posedge clk);
                tagDoneValid <= 1'b1;
                tagDoneOk <= ok;
                @(posedge clk);
                tagDoneValid <= 1'b0;
            end
        end
    end
endmodule

// file: tb/tbr_read_cmd_tb.sv
/*
  Self-checking host bench of the tag block read command.
  Assumes tbr_tag_model on the tag side.
*/
module tbr_read_cmd_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] KEY39 = 48'ha1b2c3d4e5f6;
    logic clk = 1'b0;
    logic reset_n = 1'b0, cmdWrEn = 1'b0, paramWrEn = 1'b0, keyWrEn = 1'b0;
    logic [7:0] cmdWrData = 8'h00, paramWrData = 8'h00;
    logic [3:0] paramWrAddr = 4'h0;
    logic [5:0] keyWrIdx = 6'h00;
    logic [47:0] keyWrData = 48'h0, tagCmdKey;
    logic moduleBusyLow, resultStrobe, tagCmdValid, tagCmdAuth, tagCmdKeyB;
    logic tagCmdReady, tagDoneValid, tagDoneOk, tagByteValid, tagByteReady;
    logic bufWrEn;
    logic [7:0] resultCode, tagCmdBlock, tagByte, bufWrAddr, bufWrData;
    logic [7:0] mem [256];
    int err_total = 0;
    int n_tests = 0;
    int nWr = 0;

    initial forever #2.5 clk = ~clk;

    tbr_read_cmd tbr_read_cmd_i (.clk, .reset_n, .cmdWrEn, .cmdWrData,
        .paramWrEn, .paramWrAddr, .paramWrData, .keyWrEn, .keyWrIdx,
        .keyWrData, .moduleBusyLow, .resultCode, .resultStrobe,
        .tagCmdValid, .tagCmdAuth, .tagCmdKeyB, .tagCmdBlock, .tagCmdKey,
        .tagCmdReady, .tagDoneValid, .tagDoneOk, .tagByteValid, .tagByte,
        .tagByteReady, .bufWrEn, .bufWrAddr, .bufWrData);

    tbr_tag_model tbr_tag_model_i (.clk, .reset_n, .tagCmdValid,
        .tagCmdAuth, .tagCmdKeyB, .tagCmdBlock, .tagCmdKey, .tagCmdReady,
        .tagDoneValid, .tagDoneOk, .tagByteReady, .tagByteValid,
        .tagByte);

    // buffer image, with a write count
    always @(posedge clk) begin
        if (bufWrEn === 1'b1) begin
            mem[bufWrAddr] <= bufWrData;
            nWr <= nWr + 1;
        end
    end

    task chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task give_verdict;
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // record, command, then the result code
    task run(input logic [7:0] cmd, blk, cnt, off, sel,
        input logic [47:0] key, input logic [7:0] exp);
        logic [79:0] rec;
        int n;
        rec = {key, sel, off, cnt, blk};
        n = 0;
        for (int a = 0; a < 256; a++) mem[a] = 8'hee;
        nWr = 0;
        tbr_tag_model_i.nAuth = 0;
        tbr_tag_model_i.nRead = 0;
        paramWrEn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            paramWrAddr <= 4'(i);
            paramWrData <= rec[i*8 +: 8];
            @(posedge clk);
        end
        paramWrEn <= 1'b0;
        cmdWrEn <= 1'b1;
        cmdWrData <= cmd;
        @(posedge clk);
        cmdWrEn <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (resultStrobe !== 1'b1 && n < 2000);
        if (n >= 2000) err_total++;
        chk(resultCode, exp);
    endtask

    // data from off on; neighbours and write count
    task chk_buf(input int off, blk, cnt);
        logic [7:0] b;
        for (int i = 0; i < cnt * 16; i++) begin
            b = 8'(blk + i / 16);
            chk(mem[8'(off + i)], {b[3:0], 4'(i % 16)});
        end
        chk(mem[8'(off - 1)], 8'hee);
        chk(mem[8'(off + cnt * 16)], 8'hee);
        chk(nWr, cnt * 16);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        keyWrEn <= 1'b1;
        keyWrIdx <= 6'h27;
        keyWrData <= KEY39;
        @(posedge clk);
        keyWrEn <= 1'b0;
        run(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 48'h0, 8'h00);
        run(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 48'h0, 8'h04);
        // slow tag, stored key B, three blocks across a sector edge
        tbr_tag_model_i.gap = 2;
        run(8'h02, 8'h02, 8'h03, 8'h20, 8'ha7, 48'h0, 8'h00);
        chk_buf(32, 2, 3);
        chk(tbr_tag_model_i.nAuth, 2);
        chk(tbr_tag_model_i.lastKey, KEY39);
        chk(tbr_tag_model_i.lastKeyB, 1'b1);
        tbr_tag_model_i.gap = 0;
        run(8'h02, 8'h07, 8'h01, 8'h00, 8'h40, 48'h665544332211, 8'h00);
        chk_buf(0, 7, 1);
        chk(tbr_tag_model_i.lastKey, 48'h665544332211);
        chk(tbr_tag_model_i.lastKeyB, 1'b0);
        // refused sector: nothing read, nothing written
        tbr_tag_model_i.failAuth = 9;
        run(8'h02, 8'h09, 8'h02, 8'h10, 8'h27, 48'h0, 8'h01);
        chk(tbr_tag_model_i.nRead, 0);
        chk(nWr, 0);
        tbr_tag_model_i.failAuth = -1;
        run(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 48'h0, 8'h04);
        // second block fails: first kept, second not written
        tbr_tag_model_i.failRead = 13;
        run(8'h02, 8'h0c, 8'h02, 8'h40, 8'h27, 48'h0, 8'h02);
        chk_buf(64, 12, 1);
        tbr_tag_model_i.failRead = -1;
        run(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 48'h0, 8'h04);
        run(8'h02, 8'h00, 8'h00, 8'h00, 8'h27, 48'h0, 8'h03);
        run(8'h02, 8'h00, 8'h01, 8'h00, 8'h28, 48'h0, 8'h03);
        run(8'h02, 8'h00, 8'h02, 8'he8, 8'h27, 48'h0, 8'h03);
        // last block ends at the buffer end
        run(8'h02, 8'h05, 8'h01, 8'hf0, 8'h27, 48'h0, 8'h00);
        chk_buf(240, 5, 1);
        give_verdict;
    end

    // well past the longest run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict;
    end
endmodule
